// File: cdt_consts.vh
`ifndef CDT_CONSTS_VH
`define CDT_CONSTS_VH
// register offsets (byte addresses of 16-bit registers)
`define CDT_ADDR_LOW_COUNT   8'h06
`define CDT_ADDR_HOLD        8'h08
`define CDT_ADDR_HIGH_COUNT  8'h0a
`define CDT_ADDR_LOW_PERIOD  8'h0c
`define CDT_ADDR_HIGH_PERIOD 8'h0e
`define CDT_ADDR_LOW_CTRL    8'h10
`define CDT_ADDR_HIGH_CTRL   8'h12
`define CDT_ADDR_IRQ         8'h14
// control field positions
`define CDT_BIT_ON        15
`define CDT_BIT_IDLE_STOP 13
`define CDT_BIT_GATE      6
`define CDT_BIT_PS_HI     5
`define CDT_BIT_PS_LO     4
`define CDT_BIT_CASCADE   3
`define CDT_BIT_CLK_SRC   1
// irq register field positions
`define CDT_BIT_LOW_FLAG   6
`define CDT_BIT_HIGH_FLAG  7
`define CDT_BIT_LOW_EN     14
`define CDT_BIT_HIGH_EN    15
// writable masks and reset values
`define CDT_LOW_CTRL_MASK  16'ha07a
`define CDT_HIGH_CTRL_MASK 16'ha072
`define CDT_CTRL_RESET     16'h0000
`define CDT_PERIOD_RESET   16'hffff
`define CDT_COUNT_RESET    16'h0000
// prescale terminal counts
`define CDT_PS_DIV1   8'h00
`define CDT_PS_DIV8   8'h07
`define CDT_PS_DIV64  8'h3f
`define CDT_PS_DIV256 8'hff
`endif

// File: cdt_dual_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "cdt_consts.vh"

module cdt_dual_timer (
	input  wire        clk,
	input  wire        rst,
	input  wire [7:0]  addr,
	input  wire [15:0] wrData,
	input  wire        wrStb,
	input  wire        rdStb,
	output reg  [15:0] rdData,
	input  wire        lowExtClk,
	input  wire        highExtClk,
	input  wire        cpuIdle,
	input  wire        cpuSleep,
	output reg         irq,
	output reg         adcTrigger
);

	////////////////////////////////////////////////////////////////
	function [7:0] psLimit;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: psLimit = `CDT_PS_DIV1;
				2'h1: psLimit = `CDT_PS_DIV8;
				2'h2: psLimit = `CDT_PS_DIV64;
				default: psLimit = `CDT_PS_DIV256;
			endcase
		end
	endfunction

	reg [15:0] low_count_reg;
	reg [15:0] high_count_reg;
	reg [15:0] high_word_hold_reg;
	reg [15:0] low_period_reg;
	reg [15:0] high_period_reg;
	reg [15:0] low_timer_ctrl;
	reg [15:0] high_timer_ctrl;
	reg        lowFlag;
	reg        high_timer_irq_flag;
	reg        lowIrqEn;
	reg        high_timer_irq_enable;
	reg [7:0]  lowPs;
	reg [7:0]  highPs;
	reg        lowTickSync;
	reg [2:0]  lowClkSh;
	reg [2:0]  highClkSh;
	reg        lowClkLvl;
	reg        highClkLvl;

	////////////////////////////////////////////////////////////////
	// external pin synchronisers: change accepted when stages 2 and 3 agree
	always @(posedge clk) begin
		if (rst) begin
			lowClkSh   <= 3'h0;
			highClkSh  <= 3'h0;
			lowClkLvl  <= 1'b0;
			highClkLvl <= 1'b0;
		end else begin
			lowClkSh  <= {lowClkSh[1:0], lowExtClk};
			highClkSh <= {highClkSh[1:0], highExtClk};
			if (lowClkSh[1] == lowClkSh[2])
				lowClkLvl <= lowClkSh[2];
			if (highClkSh[1] == highClkSh[2])
				highClkLvl <= highClkSh[2];
		end
	end

	wire lowRise  = lowClkSh[1] & lowClkSh[2] & ~lowClkLvl;
	wire highRise = highClkSh[1] & highClkSh[2] & ~highClkLvl;
	wire lowFall  = ~lowClkSh[1] & ~lowClkSh[2] & lowClkLvl;

	////////////////////////////////////////////////////////////////
	wire cascade = low_timer_ctrl[`CDT_BIT_CASCADE];
	wire lowOn   = low_timer_ctrl[`CDT_BIT_ON];
	// in cascade the high control register is ignored entirely
	wire highOn  = high_timer_ctrl[`CDT_BIT_ON] & ~cascade;

	// sleep stops everything; idle stops only when idle-stop is set
	wire lowRun  = lowOn & ~cpuSleep &
		~(cpuIdle & low_timer_ctrl[`CDT_BIT_IDLE_STOP]);
	wire highRun = highOn & ~cpuSleep &
		~(cpuIdle & high_timer_ctrl[`CDT_BIT_IDLE_STOP]);

	wire lowGated = low_timer_ctrl[`CDT_BIT_GATE] & ~low_timer_ctrl[`CDT_BIT_CLK_SRC];
	// counting only while gate pin high
	wire lowIn = low_timer_ctrl[`CDT_BIT_CLK_SRC] ? lowRise :
		(lowGated ? lowClkLvl : 1'b1);
	// high gate bit has no effect
	wire highIn = high_timer_ctrl[`CDT_BIT_CLK_SRC] ? highRise : 1'b1;

	wire lowPsDone  = (lowPs >= psLimit(low_timer_ctrl[`CDT_BIT_PS_HI:`CDT_BIT_PS_LO]));
	wire highPsDone = (highPs >= psLimit(high_timer_ctrl[`CDT_BIT_PS_HI:`CDT_BIT_PS_LO]));
	wire lowTickRaw = lowRun & lowIn & lowPsDone;
	// low output is registered (resync), high output is used directly
	wire lowTick  = lowTickSync;
	wire highTick = highRun & highIn & highPsDone;

	wire wrLowCnt  = wrStb & (addr == `CDT_ADDR_LOW_COUNT);
	wire wrHighCnt = wrStb & (addr == `CDT_ADDR_HIGH_COUNT);
	wire wrLowCtl  = wrStb & (addr == `CDT_ADDR_LOW_CTRL);
	wire wrHighCtl = wrStb & (addr == `CDT_ADDR_HIGH_CTRL);

	// in cascade, high-count writes also restart the single prescaler
	wire lowPsClr  = wrLowCnt | wrLowCtl | (cascade & wrHighCnt);
	wire highPsClr = wrHighCnt | wrHighCtl;

	////////////////////////////////////////////////////////////////
	// prescalers
	always @(posedge clk) begin
		if (rst) begin
			lowPs       <= 8'h00;
			highPs      <= 8'h00;
			lowTickSync <= 1'b0;
		end else begin
			lowTickSync <= lowTickRaw;
			// a prescaler cannot be cleared while its timer is off; sleep or idle stop does not block the clear
			if (lowOn && lowPsClr)
				lowPs <= 8'h00;
			else if (lowRun && lowIn)
				lowPs <= lowPsDone ? 8'h00 : lowPs + 8'h01;
			if (highOn && highPsClr)
				highPs <= 8'h00;
			else if (highRun && highIn)
				highPs <= highPsDone ? 8'h00 : highPs + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	wire [31:0] count32  = {high_count_reg, low_count_reg};
	wire [31:0] period32 = {high_period_reg, low_period_reg};
	wire match32   = (count32 == period32);
	wire lowMatch  = (low_count_reg == low_period_reg);
	wire highMatch = (high_count_reg == high_period_reg);
	wire [31:0] inc32 = count32 + 32'h00000001;

	wire wrHold    = wrStb & (addr == `CDT_ADDR_HOLD);
	wire wrLowPer  = wrStb & (addr == `CDT_ADDR_LOW_PERIOD);
	wire wrHighPer = wrStb & (addr == `CDT_ADDR_HIGH_PERIOD);
	wire wrIrq     = wrStb & (addr == `CDT_ADDR_IRQ);
	wire rdLowCnt  = rdStb & (addr == `CDT_ADDR_LOW_COUNT);
	// gate fall only ends an accumulation while the timer runs
	wire lowGateEnd = lowRun & lowGated & lowFall;

	////////////////////////////////////////////////////////////////
	// split-mode count step: wraps to zero on the period tick
	function [15:0] next16;
		input [15:0] cur;
		input [15:0] per;
		begin
			if (cur == per)
				next16 = 16'h0000;
			else
				next16 = cur + 16'h0001;
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// converter trigger: one-cycle pulse per 32-bit match tick in cascade, per high-timer match tick in split mode
	always @(posedge clk) begin
		if (rst) begin
			adcTrigger <= 1'b0;
		end else begin
			if (cascade)
				adcTrigger <= lowTick & match32;
			else
				adcTrigger <= highTick & highMatch;
		end
	end

	////////////////////////////////////////////////////////////////
	// counts: a software write beats a same-cycle tick
	always @(posedge clk) begin
		if (rst) begin
			low_count_reg  <= `CDT_COUNT_RESET;
			high_count_reg <= `CDT_COUNT_RESET;
		end else begin
			if (wrLowCnt) begin
				low_count_reg <= wrData;
			end else if (cascade && lowTick) begin
				low_count_reg <= match32 ? 16'h0000 : inc32[15:0];
			end else if (!cascade && lowTick) begin
				low_count_reg <= next16(low_count_reg, low_period_reg);
			end
			if (wrLowCnt && cascade) begin
				high_count_reg <= high_word_hold_reg;
			end else if (wrHighCnt) begin
				high_count_reg <= wrData;
			end else if (cascade && lowTick) begin
				high_count_reg <= match32 ? 16'h0000 : inc32[31:16];
			end else if (!cascade && highTick) begin
				high_count_reg <= next16(high_count_reg, high_period_reg);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// hold, periods and controls
	always @(posedge clk) begin
		if (rst) begin
			high_word_hold_reg <= `CDT_COUNT_RESET;
			low_period_reg     <= `CDT_PERIOD_RESET;
			high_period_reg    <= `CDT_PERIOD_RESET;
			low_timer_ctrl     <= `CDT_CTRL_RESET;
			high_timer_ctrl    <= `CDT_CTRL_RESET;
		end else begin
			// snapshot keeps a 32-bit read coherent across a carry
			if (rdLowCnt)
				high_word_hold_reg <= high_count_reg;
			else if (wrHold)
				high_word_hold_reg <= wrData;
			if (wrLowPer)
				low_period_reg <= wrData;
			if (wrHighPer)
				high_period_reg <= wrData;
			// counts are left alone by control writes
			if (wrLowCtl)
				low_timer_ctrl <= wrData & `CDT_LOW_CTRL_MASK;
			if (wrHighCtl)
				high_timer_ctrl <= wrData & `CDT_HIGH_CTRL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////
	// flags: set comes after the write so hardware wins
	always @(posedge clk) begin
		if (rst) begin
			lowFlag               <= 1'b0;
			high_timer_irq_flag   <= 1'b0;
			lowIrqEn              <= 1'b0;
			high_timer_irq_enable <= 1'b0;
		end else begin
			if (wrIrq) begin
				lowIrqEn              <= wrData[`CDT_BIT_LOW_EN];
				high_timer_irq_enable <= wrData[`CDT_BIT_HIGH_EN];
				lowFlag               <= wrData[`CDT_BIT_LOW_FLAG];
				high_timer_irq_flag   <= wrData[`CDT_BIT_HIGH_FLAG];
			end
			if (cascade) begin
				if ((lowTick && match32) || lowGateEnd)
					high_timer_irq_flag <= 1'b1;
			end else begin
				if ((lowTick && lowMatch) || lowGateEnd)
					lowFlag <= 1'b1;
				if (highTick && highMatch)
					high_timer_irq_flag <= 1'b1;
			end
		end
	end

	always @(posedge clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= (high_timer_irq_flag & high_timer_irq_enable) |
				(lowFlag & lowIrqEn & ~cascade);
	end

	////////////////////////////////////////////////////////////////
	// read mux: zero outside the cycle after a read strobe
	reg [15:0] next_rdData;

	always @* begin
		next_rdData = 16'h0000;
		if (rdStb) begin
			case (addr)
				`CDT_ADDR_LOW_COUNT:   next_rdData = low_count_reg;
				`CDT_ADDR_HOLD:        next_rdData = high_word_hold_reg;
				`CDT_ADDR_HIGH_COUNT:  next_rdData = high_count_reg;
				`CDT_ADDR_LOW_PERIOD:  next_rdData = low_period_reg;
				`CDT_ADDR_HIGH_PERIOD: next_rdData = high_period_reg;
				`CDT_ADDR_LOW_CTRL:    next_rdData = low_timer_ctrl;
				`CDT_ADDR_HIGH_CTRL:   next_rdData = high_timer_ctrl;
				`CDT_ADDR_IRQ: begin
					next_rdData[`CDT_BIT_LOW_EN]    = lowIrqEn;
					next_rdData[`CDT_BIT_HIGH_EN]   = high_timer_irq_enable;
					next_rdData[`CDT_BIT_LOW_FLAG]  = lowFlag;
					next_rdData[`CDT_BIT_HIGH_FLAG] = high_timer_irq_flag;
				end
				default: next_rdData = 16'h0000;
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst)
			rdData <= 16'h0000;
		else
			rdData <= next_rdData;
	end

endmodule
`default_nettype wire

// File: cdt_dual_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "cdt_consts.vh"
module cdt_dual_timer_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wrData,
	input wire logic        wrStb,
	input wire logic        rdStb,
	input wire logic [15:0] rdData,
	input wire logic        cpuSleep,
	input wire logic        irq,
	input wire logic        adcTrigger
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	read_idle_zero_a: assert property (!rdStb |=> rdData == 16'h0000)
		else $error("read data not zero");
	unmapped_read_a: assert property (rdStb && addr == 8'h00 |=> rdData == 16'h0000)
		else $error("unmapped read not zero");
	low_ctrl_mask_a: assert property (rdStb && addr == `CDT_ADDR_LOW_CTRL
		|=> (rdData & ~`CDT_LOW_CTRL_MASK) == 16'h0000) else $error("low ctrl bits");
	high_ctrl_mask_a: assert property (rdStb && addr == `CDT_ADDR_HIGH_CTRL
		|=> (rdData & ~`CDT_HIGH_CTRL_MASK) == 16'h0000) else $error("high ctrl bits");
	hold_write_a: assert property (wrStb && addr == `CDT_ADDR_HOLD ##1 !rdStb
		##1 rdStb && addr == `CDT_ADDR_HOLD |=> rdData == $past(wrData, 3))
		else $error("hold readback");
	period_write_a: assert property (wrStb && addr == `CDT_ADDR_LOW_PERIOD ##1 !wrStb
		##1 rdStb && addr == `CDT_ADDR_LOW_PERIOD |=> rdData == $past(wrData, 3))
		else $error("period readback");
	sleep_quiet_a: assert property (cpuSleep [*5] |-> !adcTrigger)
		else $error("trigger during sleep");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !irq && !adcTrigger)
		else $error("outputs active after reset");
	cover property (adcTrigger);
	cover property (irq);
	cover property (rdStb && addr == `CDT_ADDR_HOLD);
endmodule
bind cdt_dual_timer cdt_dual_timer_sva chk (.clk(clk), .rst(rst), .addr(addr),
	.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .cpuSleep(cpuSleep),
	.irq(irq), .adcTrigger(adcTrigger));
`default_nettype wire

// File: cdt_ext_source.sv
`timescale 1ns/10ps
`default_nettype none
module cdt_ext_source (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic       clkMode,
	input  wire logic [7:0] len,
	output var  logic       pin
);
	logic [9:0] left = 10'h000;
	initial pin = 1'b0;
	// in clock mode, two-cycle high pulses keep each edge visible to the synchroniser; otherwise one gate pulse of len cycles
	always @(posedge clk) begin
		if (start)
			left <= clkMode ? {len, 2'b00} : {2'b00, len};
		else if (left != 10'h000)
			left <= left - 10'h001;
		pin <= clkMode ? left[1] : (start | left > 10'h001);
	end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cdt_consts.vh"
module tb;
	localparam [7:0] lowCnt = `CDT_ADDR_LOW_COUNT, hold = `CDT_ADDR_HOLD;
	localparam [7:0] irqReg = `CDT_ADDR_IRQ, highCnt = `CDT_ADDR_HIGH_COUNT;
	localparam [7:0] lowPer = `CDT_ADDR_LOW_PERIOD, highPer = `CDT_ADDR_HIGH_PERIOD;
	localparam [7:0] lowCtrl = `CDT_ADDR_LOW_CTRL, highCtrl = `CDT_ADDR_HIGH_CTRL;
	reg         clk = 1'b0, rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
	reg         cpuIdle = 1'b0, cpuSleep = 1'b0, start = 1'b0, clkMode = 1'b0;
	reg [7:0]   addr = 8'h00, len = 8'h00;
	reg [15:0]  wrData = 16'h0000, got;
	wire [15:0] rdData;
	wire        irq, adcTrigger, pin;
	integer     fails = 0, compares = 0, n, i;
	always #12.5 clk = ~clk;
	cdt_dual_timer dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .lowExtClk(pin), .highExtClk(pin), .cpuIdle(cpuIdle),
		.cpuSleep(cpuSleep), .irq(irq), .adcTrigger(adcTrigger));
	cdt_ext_source src (.clk(clk), .start(start), .clkMode(clkMode), .len(len), .pin(pin));
	task conclude;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 got = rdData;
	endtask
	task rdc(input string what, input [7:0] a, input [15:0] exp);
		rd(a);
		chk(what, got, exp);
	endtask
	// interval in cycles up to the next trigger; 3000 means none came
	task trig;
		n = 0;
		do begin
			@(posedge clk);
			#1 n = n + 1;
		end while (adcTrigger !== 1'b1 && n < 3000);
	endtask
	task pulse(input m, input [7:0] l);
		@(posedge clk);
		clkMode <= m;
		len <= l;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (4 * l + 10) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdc("low period", lowPer, 16'hffff);
		rdc("low ctrl", lowCtrl, 16'h0000);
		rdc("high ctrl", highCtrl, 16'h0000);
		rdc("unmapped", 8'h00, 16'h0000);
		wr(highPer, 16'h0001);
		for (i = 0; i < 4; i = i + 1) begin
			wr(highCtrl, {10'h200, i[1:0], 4'h0});
			wr(highCnt, 16'h0000);
			trig;
			trig;
			chk("prescale", n, (i == 3) ? 512 : 2 << (3 * i));
		end
		wr(highPer, 16'hffff);
		wr(lowCtrl, 16'h8008);
		wr(hold, 16'h0001);
		rdc("hold", hold, 16'h0001);
		wr(lowCnt, 16'hfffd);
		repeat (4) @(posedge clk);
		rd(lowCnt);
		chk("low half", got < 16'h0010, 1);
		rdc("hold latch", hold, 16'h0002);
		wr(lowPer, 16'h0005);
		rdc("low period", lowPer, 16'h0005);
		wr(highPer, 16'h0000);
		wr(hold, 16'h0000);
		wr(lowCnt, 16'h0000);
		trig;
		trig;
		chk("period32", n, 6);
		@(posedge clk);
		cpuSleep <= 1'b1;
		repeat (4) @(posedge clk);
		trig;
		chk("sleep", n, 3000);
		cpuSleep <= 1'b0;
		wr(lowCtrl, 16'ha008);
		cpuIdle <= 1'b1;
		repeat (4) @(posedge clk);
		trig;
		chk("idle stop", n, 3000);
		wr(lowCtrl, 16'h8008);
		trig;
		trig;
		chk("idle run", n, 6);
		cpuIdle <= 1'b0;
		wr(lowPer, 16'hffff);
		wr(highPer, 16'hffff);
		wr(irqReg, 16'h8000);
		wr(lowCtrl, 16'h8048);
		wr(lowCnt, 16'h0000);
		pulse(1'b0, 8'd20);
		rd(lowCnt);
		chk("gated", got > 16'h000f && got < 16'h0019, 1);
		rdc("gate kept", lowCnt, got);
		chk("gate irq", irq, 1);
		rdc("gate flag", irqReg, 16'h8080);
		wr(irqReg, 16'h8000);
		rdc("flag clear", irqReg, 16'h8000);
		chk("irq clear", irq, 0);
		wr(lowCtrl, 16'h800a);
		wr(lowCnt, 16'h0000);
		pulse(1'b1, 8'd10);
		rdc("ext edges", lowCnt, 16'h000a);
		wr(lowCtrl, 16'h800a);
		rdc("ctrl keeps", lowCnt, 16'h000a);
		conclude;
	end
	initial begin
		#1000000;
		fails = fails + 1;
		conclude;
	end
endmodule
`default_nettype wire
